/* rtl/dis_pkg.sv */
package dis_pkg;
   localparam int DIS_CLK_MHZ = 200;
   localparam int DIS_CHANNELS = 8;
   // Debounce and monitor times in microseconds
   localparam int DIS_DB_SHORT_US = 1000;
   localparam int DIS_DB_LONG_US = 3000;
   localparam int DIS_MON_FALL_US = 1000;
   localparam int DIS_MON_RISE_US = 6000;
   localparam int DIS_DB_SHORT_CYC = DIS_DB_SHORT_US * DIS_CLK_MHZ;
   localparam int DIS_DB_LONG_CYC = DIS_DB_LONG_US * DIS_CLK_MHZ;
   localparam int DIS_MON_FALL_CYC = DIS_MON_FALL_US * DIS_CLK_MHZ;
   localparam int DIS_MON_RISE_CYC = DIS_MON_RISE_US * DIS_CLK_MHZ;
   localparam int DIS_CNT_W = 24;

   typedef enum logic [1:0]
   {
      DIS_DB_RESERVED = 2'h0,
      // Code is {select1, select0}; select0 open with select1 grounded bypasses
      DIS_DB_BYPASS = 2'h1,
      DIS_DB_1MS = 2'h2,
      DIS_DB_3MS = 2'h3
   } dis_db_sel_t;

   // Host-side serial port pins
   typedef struct packed
   {
      logic load_n;
      logic shift_clk;
      logic clk_en_n;
      logic serial_input;
   } dis_link_t;

   // Chip health sensing
   typedef struct packed
   {
      logic supply_low;
      logic supply_high;
      logic over_temp;
      logic shutdown_temp;
   } dis_health_t;
endpackage : dis_pkg

/* rtl/dis_debounce.sv */
`timescale 1ns/1ps
module dis_debounce
#(
   parameter int LONG_CYC = dis_pkg::DIS_DB_LONG_CYC,
   parameter int SHORT_CYC = dis_pkg::DIS_DB_SHORT_CYC
)
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic raw_i,
   input wire dis_pkg::dis_db_sel_t sel_i,
   output logic valid_o
);
   import dis_pkg::*;

   logic [DIS_CNT_W-1:0] cnt_q;
   logic [DIS_CNT_W-1:0] cnt_d;
   logic state_q;
   logic state_d;
   logic [DIS_CNT_W-1:0] limit;

   initial
   begin
      if (LONG_CYC < 1 || SHORT_CYC < 1 || LONG_CYC >= (1 << DIS_CNT_W))
         $error("dis_debounce: bad debounce count");
   end

   always_comb
   begin
      limit = DIS_CNT_W'(LONG_CYC);
      state_d = state_q;
      cnt_d = '0;
      case (sel_i)
         DIS_DB_1MS: limit = DIS_CNT_W'(SHORT_CYC);
         DIS_DB_3MS: limit = DIS_CNT_W'(LONG_CYC);
         // Reserved code treated as longest delay, the safe choice
         default: limit = DIS_CNT_W'(LONG_CYC);
      endcase
      if (sel_i == DIS_DB_BYPASS)
      begin
         state_d = raw_i;
      end
      else if (raw_i != state_q)
      begin
         // Level must persist for the whole time, any bounce restarts
         if (cnt_q + 1'b1 >= limit)
            state_d = raw_i;
         else
            cnt_d = cnt_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         cnt_q <= '0;
         state_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         state_q <= state_d;
      end
   end

   assign valid_o = state_q;

   debounce_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (sel_i != DIS_DB_BYPASS && state_q != raw_i && cnt_q + 1'b1 < limit) |=> $stable(state_q))
      else $error("debounced state changed too early");
endmodule : dis_debounce

/* rtl/dis_serializer.sv */
`timescale 1ns/1ps
module dis_serializer
#(
   parameter int CHANNELS = dis_pkg::DIS_CHANNELS,
   parameter int DB_LONG_CYC = dis_pkg::DIS_DB_LONG_CYC,
   parameter int DB_SHORT_CYC = dis_pkg::DIS_DB_SHORT_CYC,
   parameter int MON_FALL_CYC = dis_pkg::DIS_MON_FALL_CYC,
   parameter int MON_RISE_CYC = dis_pkg::DIS_MON_RISE_CYC
)
(
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [CHANNELS-1:0] field_input_i,
   input wire logic debounce_select0_i,
   input wire logic debounce_select1_i,
   input wire dis_pkg::dis_link_t link_i,
   input wire dis_pkg::dis_health_t health_i,
   output logic serial_output_o,
   output logic serial_output_oe_o,
   output logic health_output_o,
   output logic health_output_oe_o,
   output logic [CHANNELS-1:0] status_indicator_return_o
);
   import dis_pkg::*;

   initial
   begin
      if (CHANNELS < 2 || MON_FALL_CYC < 1 || MON_RISE_CYC < 1 || MON_RISE_CYC >= (1 << DIS_CNT_W))
         $error("dis_serializer: bad parameter");
   end

   // Two-flop synchronisers; first stage read only by second
   localparam int SYW = CHANNELS + $bits(dis_db_sel_t) + $bits(dis_link_t) + $bits(dis_health_t);
   logic [SYW-1:0] sync1_q;
   logic [SYW-1:0] sync2_q;
   logic [SYW-1:0] sync_in;
   assign sync_in = {field_input_i, debounce_select1_i, debounce_select0_i, link_i, health_i};

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= sync_in;
         sync2_q <= sync1_q;
      end
   end

   logic [CHANNELS-1:0] field_s;
   dis_db_sel_t sel_s;
   dis_link_t link_s;
   dis_health_t health_s;
   logic [$bits(dis_db_sel_t)-1:0] sel_raw;
   // Split mirrors the concatenation above, so no bit positions are written out
   assign {field_s, sel_raw, link_s, health_s} = sync2_q;
   assign sel_s = dis_db_sel_t'(sel_raw);

   logic [CHANNELS-1:0] valid_bits;
   for (genvar g = 0; g < CHANNELS; g++)
   begin : g_db
      dis_debounce #(.LONG_CYC(DB_LONG_CYC), .SHORT_CYC(DB_SHORT_CYC)) u_db
      (
         .core_clk_i(core_clk_i),
         .nrst_i(nrst_i),
         .raw_i(field_s[g]),
         .sel_i(sel_s),
         .valid_o(valid_bits[g])
      );
   end

   // Shift register; bit CHANNELS-1 is the output-side stage
   logic [CHANNELS-1:0] sreg_q;
   logic [CHANNELS-1:0] sreg_d;
   logic sclk_prev_q;
   logic sclk_rise;
   assign sclk_rise = link_s.shift_clk && !sclk_prev_q;

   always_comb
   begin
      sreg_d = sreg_q;
      if (!link_s.load_n)
         sreg_d = valid_bits;
      else if (!link_s.clk_en_n && sclk_rise)
         sreg_d = {sreg_q[CHANNELS-2:0], link_s.serial_input};
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         sreg_q <= '0;
         sclk_prev_q <= 1'b0;
      end
      else
      begin
         sreg_q <= sreg_d;
         sclk_prev_q <= link_s.shift_clk;
      end
   end

   // Supply monitor with asymmetric qualification times
   logic sup_ok_q;
   logic sup_ok_d;
   logic [DIS_CNT_W-1:0] mon_cnt_q;
   logic [DIS_CNT_W-1:0] mon_cnt_d;
   logic shut_q;
   logic shut_d;

   always_comb
   begin
      sup_ok_d = sup_ok_q;
      mon_cnt_d = '0;
      if (sup_ok_q && health_s.supply_low)
      begin
         if (mon_cnt_q + 1'b1 >= DIS_CNT_W'(MON_FALL_CYC))
            sup_ok_d = 1'b0;
         else
            mon_cnt_d = mon_cnt_q + 1'b1;
      end
      else if (!sup_ok_q && health_s.supply_high)
      begin
         if (mon_cnt_q + 1'b1 >= DIS_CNT_W'(MON_RISE_CYC))
            sup_ok_d = 1'b1;
         else
            mon_cnt_d = mon_cnt_q + 1'b1;
      end
      // Shutdown latches until reset; cooling alone does not restart outputs
      shut_d = shut_q | health_s.shutdown_temp;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         sup_ok_q <= 1'b0;
         mon_cnt_q <= '0;
         shut_q <= 1'b0;
      end
      else
      begin
         sup_ok_q <= sup_ok_d;
         mon_cnt_q <= mon_cnt_d;
         shut_q <= shut_d;
      end
   end

   logic health_q;
   logic sop_q;
   logic [CHANNELS-1:0] ind_q;
   always_ff @(posedge core_clk_i)
   begin
      if (!nrst_i)
      begin
         health_q <= 1'b0;
         sop_q <= 1'b0;
         ind_q <= '0;
      end
      else
      begin
         // Shutdown clears health in the same cycle the drivers are released
         health_q <= sup_ok_q && !health_s.over_temp && !shut_d;
         sop_q <= sreg_d[CHANNELS-1];
         ind_q <= shut_d ? '0 : field_s;
      end
   end

   assign serial_output_o = sop_q;
   assign serial_output_oe_o = !shut_q;
   assign health_output_o = health_q;
   assign health_output_oe_o = !shut_q;
   assign status_indicator_return_o = ind_q;

   load_capture_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      !link_s.load_n |=> sreg_q == $past(valid_bits))
      else $error("parallel load missed");
   shift_step_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (link_s.load_n && !link_s.clk_en_n && sclk_rise) |=> sreg_q[0] == $past(link_s.serial_input))
      else $error("serial input not shifted in");
   hold_enable_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (link_s.load_n && link_s.clk_en_n) |=> $stable(sreg_q))
      else $error("register changed while disabled");
   // Output-side stage shows on the pin right after load, before any shift clock
   sop_follow_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      !link_s.load_n |=> serial_output_o == $past(valid_bits[CHANNELS-1]))
      else $error("serial output not at output stage");
   bit_walk_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      (link_s.load_n && !link_s.clk_en_n && sclk_rise) |=> sreg_q[CHANNELS-1] == $past(sreg_q[CHANNELS-2]))
      else $error("shift did not advance toward output");
   supply_fall_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      $fell(sup_ok_q) |-> $past(health_s.supply_low) && $past(mon_cnt_q) == DIS_CNT_W'(MON_FALL_CYC - 1))
      else $error("supply fault not after fall delay");
   supply_rise_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      $rose(sup_ok_q) |-> $past(mon_cnt_q) == DIS_CNT_W'(MON_RISE_CYC - 1))
      else $error("supply ok not after rise delay");
   temp_fault_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      health_s.over_temp |=> !health_output_o)
      else $error("over temperature left health high");
   indicator_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      !shut_d |=> status_indicator_return_o == $past(field_s))
      else $error("indicator not following input");
   shutdown_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
      shut_q |-> !serial_output_oe_o && !health_output_oe_o && !health_output_o)
      else $error("outputs driven during shutdown");
endmodule : dis_serializer

/* dv/dis_host_model.sv */
`timescale 1ns/1ps
module dis_host_model
(
   input wire logic serial_output_i,
   input wire logic serial_output_oe_i,
   output dis_pkg::dis_link_t link_o
);
   import dis_pkg::*;
   logic last_q;
   initial link_o = 4'ha;
   // A released line shows the inverse of its last level, never a stale match
   always @(serial_output_i or serial_output_oe_i)
      if (serial_output_oe_i)
         last_q = serial_output_i;
   task automatic read_frame(input int nbits, input logic [7:0] chain, output logic [15:0] word);
      word = '0;
      #1.3;
      link_o.load_n = 1'b0;
      #30;
      link_o.load_n = 1'b1;
      #30;
      link_o.clk_en_n = 1'b0;
      #30;
      for (int i = 0; i < nbits; i++)
      begin
         word = {word[14:0], serial_output_oe_i ? serial_output_i : ~last_q};
         link_o.serial_input = (i < 8) ? chain[7-i] : 1'b0;
         #24;
         link_o.shift_clk = 1'b1;
         #24;
         link_o.shift_clk = 1'b0;
      end
      // Clock stands still between frames
      link_o.clk_en_n = 1'b1;
   endtask : read_frame
endmodule : dis_host_model

/* dv/tb_debounced_input_serializer.sv */
`timescale 1ns/1ps
module tb_debounced_input_serializer;
   import dis_pkg::*;
   logic clk;
   logic nrst;
   logic [7:0] field;
   logic sel0;
   logic sel1;
   dis_link_t link;
   dis_health_t health;
   logic sop;
   logic sop_oe;
   logic hlth;
   logic hlth_oe;
   logic [7:0] status;
   logic [15:0] word;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   // Internal pulldown holds the pin low once released
   wire health_wire = hlth_oe ? hlth : 1'b0;
   dis_serializer #(.DB_LONG_CYC(150), .DB_SHORT_CYC(40), .MON_FALL_CYC(10), .MON_RISE_CYC(30)) i_dut
   (
      .core_clk_i(clk),
      .nrst_i(nrst),
      .field_input_i(field),
      .debounce_select0_i(sel0),
      .debounce_select1_i(sel1),
      .link_i(link),
      .health_i(health),
      .serial_output_o(sop),
      .serial_output_oe_o(sop_oe),
      .health_output_o(hlth),
      .health_output_oe_o(hlth_oe),
      .status_indicator_return_o(status)
   );
   dis_host_model i_host
   (
      .serial_output_i(sop),
      .serial_output_oe_i(sop_oe),
      .link_o(link)
   );
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic wrap_up();
      if (fails == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fails++;
         wrap_up();
      end
   end
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_cyc
   // Three frames: at once, one frame later, and after a further 60 cycles
   task automatic db_step(input logic s0, input logic s1, input logic [7:0] val, input logic [7:0] e1,
                          input logic [7:0] e2);
      @(negedge clk);
      sel0 = s0;
      sel1 = s1;
      field = val;
      wait_cyc(4);
      chk("status", {8'h00, val}, {8'h00, status});
      i_host.read_frame(8, 8'h00, word);
      chk("frame1", {8'h00, e1}, word);
      i_host.read_frame(8, 8'h00, word);
      chk("frame2", {8'h00, e2}, word);
      wait_cyc(60);
      i_host.read_frame(8, 8'h00, word);
      chk("frame3", {8'h00, val}, word);
   endtask : db_step
   task automatic chk_health(input logic exp, input int n);
      wait_cyc(n);
      chk("health", {15'h0000, exp}, {15'h0000, health_wire});
   endtask : chk_health
   initial
   begin
      nrst = 1'b0;
      field = 8'ha5;
      sel0 = 1'b1;
      sel1 = 1'b0;
      health = '0;
      wait_cyc(10);
      nrst = 1'b1;
      wait_cyc(10);
      chk("sop_oe", 16'h0001, {15'h0000, sop_oe});
      i_host.read_frame(16, 8'h3c, word);
      chk("chain", 16'ha53c, word);
      db_step(1'b1, 1'b0, 8'h5a, 8'h5a, 8'h5a);
      db_step(1'b0, 1'b1, 8'ha5, 8'h5a, 8'ha5);
      db_step(1'b1, 1'b1, 8'h5a, 8'ha5, 8'ha5);
      db_step(1'b0, 1'b0, 8'ha5, 8'h5a, 8'h5a);
      wait_cyc(1);
      health.supply_high = 1'b1;
      chk_health(1'b0, 25);
      chk_health(1'b1, 15);
      health.supply_high = 1'b0;
      health.supply_low = 1'b1;
      chk_health(1'b1, 6);
      chk_health(1'b0, 10);
      health.supply_low = 1'b0;
      health.supply_high = 1'b1;
      chk_health(1'b1, 40);
      health.over_temp = 1'b1;
      chk_health(1'b0, 4);
      health.over_temp = 1'b0;
      chk_health(1'b1, 4);
      health.shutdown_temp = 1'b1;
      chk_health(1'b0, 4);
      chk("outputs_oe", 16'h0000, {14'h0000, sop_oe, hlth_oe});
      wrap_up();
   end
endmodule : tb_debounced_input_serializer
